//--- bench/cps_bus_model.sv
// Purpose: Idle CAN bus seen through bit timing ticks.
// Assumes: Other nodes silent, so every sampled bit is recessive.
// Notes: Slow mode spaces ticks four clocks apart.
`timescale 1ns/100ps
module cps_bus_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  output logic bit_tick,
  output logic bit_recessive
);
  logic [1:0] div_reg; // Bit time divider
  logic [1:0] div_next;
  // Free running divider, bus idles between frames
  always_comb begin
    div_next = div_reg + 2'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_reg <= 2'h0;
    else div_reg <= div_next;
  end
  assign bit_tick = slow ? (div_reg == 2'h3) : div_reg[0];
  assign bit_recessive = 1'h1; // Idle bus reads recessive
endmodule : cps_bus_model

//--- bench/cps_status_assertions.sv
// Purpose: Port checks for the protocol status block.
// Assumes: Engine inputs held steady around status reads.
// Notes: Bound onto every cps_status instance.
`timescale 1ns/100ps
module cps_status_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [8:0] tx_fault_count,
  input wire logic [8:0] rx_fault_count,
  input wire logic passive_state,
  input wire logic enter_bus_off,
  input wire logic [1:0] activity_state,
  input wire logic init_hold_bit,
  input wire logic counters_clear,
  input wire logic bus_off_flag
);
  logic rd_reg; // Status read now in data phase
  logic rd_next;
  // Track status reads so hrdata is judged only then
  always_comb begin
    rd_next = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_reg <= 1'h0;
    else rd_reg <= rd_next;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  busoff_sets_a: assert property (enter_bus_off |=> bus_off_flag && init_hold_bit)
    else $error("bus-off did not set flag and hold");
  busoff_cause_a: assert property ($rose(bus_off_flag) |-> $past(enter_bus_off))
    else $error("bus-off flag rose without cause");
  busoff_read_a: assert property (rd_reg |-> hrdata[7] == $past(bus_off_flag))
    else $error("bus-off bit wrong");
  warn_read_a: assert property (rd_reg |-> hrdata[6] ==
    ($past(tx_fault_count) >= 9'h060 || $past(rx_fault_count) >= 9'h060))
    else $error("warning bit wrong");
  passive_read_a: assert property (rd_reg |-> hrdata[5] == $past(passive_state))
    else $error("passive bit wrong");
  act_read_a: assert property (rd_reg |-> hrdata[4:3] == $past(activity_state))
    else $error("activity field wrong");
  clear_pulse_a: assert property (counters_clear |=> !counters_clear)
    else $error("counter clear not a pulse");
  clear_end_a: assert property (counters_clear |-> ##[0:2] !bus_off_flag)
    else $error("bus-off kept after recovery");
  clear_when_a: assert property (counters_clear |-> $past(bus_off_flag))
    else $error("counter clear outside recovery");
  cover property (rd_reg);
  cover property (enter_bus_off);
  cover property (counters_clear);
endmodule : cps_status_checker
bind cps_status cps_status_checker i_cps_status_checker (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .tx_fault_count, .rx_fault_count, .passive_state, .enter_bus_off,
  .activity_state, .init_hold_bit, .counters_clear, .bus_off_flag);

//--- bench/cps_status_bench.sv
// Purpose: Self-checking bench for the protocol status block.
// Assumes: Single AHB-Lite slave, ready taken from hreadyout.
// Notes: Recovery runs on slow ticks, so it spans some 6000 clocks.
`timescale 1ns/100ps
module cps_status_bench;
  import cps_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, activity_state;
  logic [2:0] hsize;
  logic [8:0] tx_fault_count, rx_fault_count;
  logic passive_state, enter_bus_off, event_valid, data_phase, slow;
  logic fd_crc_fixed_stuff, bit_tick, bit_recessive, counting;
  logic init_hold_bit, counters_clear, bus_off_flag;
  cps_event_t event_kind;
  int n_fail, comparisons, nticks;
  assign hready = hreadyout; // Only slave on the bus
  cps_status i_cps_status (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .tx_fault_count, .rx_fault_count, .passive_state, .enter_bus_off,
    .activity_state, .event_valid, .event_kind, .data_phase,
    .fd_crc_fixed_stuff, .bit_tick, .bit_recessive, .init_hold_bit,
    .counters_clear, .bus_off_flag);
  cps_bus_model i_cps_bus_model (.hclk, .hresetn, .slow, .bit_tick,
    .bit_recessive);
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  // Count bit times seen during the recovery wait
  always @(posedge hclk) if (counting && bit_tick) nticks <= nticks + 1;
  task chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One single transfer, waits on ready in both phases
  task ahb(logic wr, logic [7:0] a, logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata;
  endtask : ahb
  task ev(cps_event_t k, logic dp, logic fix);
    @(posedge hclk);
    event_valid <= 1'h1;
    event_kind <= k;
    data_phase <= dp;
    fd_crc_fixed_stuff <= fix;
    @(posedge hclk);
    event_valid <= 1'h0;
  endtask : ev
  task t_reset;
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("status", r, 32'h0000070F);
    ahb(1'h0, 8'h0C, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask : t_reset
  task t_flags;
    logic [8:0] txv [4] = '{9'h05F, 9'h060, 9'h000, 9'h05F};
    logic [8:0] rxv [4] = '{9'h000, 9'h000, 9'h060, 9'h05F};
    for (int i = 0; i < 4; i++) begin
      tx_fault_count <= txv[i];
      rx_fault_count <= rxv[i];
      passive_state <= i[0];
      activity_state <= i[1:0];
      ahb(1'h0, CPS_OFS_STATUS, 32'h0);
      chk("warn", r[6], 32'(i == 1 || i == 2));
      chk("passive", r[5], i[0]);
      chk("activity", r[4:3], i[1:0]);
    end
  endtask : t_flags
  task t_codes;
    for (int k = 0; k < 7; k++) begin
      ev(cps_event_t'(k), 1'h0, 1'h0);
      ahb(1'h0, CPS_OFS_STATUS, 32'h0);
      chk("code", r[2:0], k[2:0]);
      ahb(1'h0, CPS_OFS_STATUS, 32'h0);
      chk("reread", r[2:0], CPS_CODE_NOCHG);
    end
    ev(CPS_EV_STUFF, 1'h1, 1'h0);
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("data code", r[10:8], CPS_CODE_STUFF);
    chk("lec untouched", r[2:0], CPS_CODE_NOCHG);
    ev(CPS_EV_OK, 1'h1, 1'h0);
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("data ok", r[10:8], CPS_CODE_NONE);
    ev(CPS_EV_STUFF, 1'h0, 1'h1);
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("fixed stuff", r[2:0], CPS_CODE_FORM);
  endtask : t_codes
  // Bus-off, host release, idle runs, then counters cleared
  task t_busoff;
    enter_bus_off <= 1'h1;
    @(posedge hclk);
    enter_bus_off <= 1'h0;
    slow <= 1'h1;
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("bus off", r[7], 1'h1);
    chk("hold", init_hold_bit, 1'h1);
    ahb(1'h1, CPS_OFS_CTRL, 32'h0);
    counting = 1'h1;
    for (int i = 0; i < 5000 && nticks < 330; i++) @(posedge hclk);
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("idle code", r[2:0], CPS_CODE_BIT0);
    ahb(1'h0, CPS_OFS_CNT, 32'h0);
    chk("runs", 32'(r[15:8] >= 8'h1D && r[15:8] <= 8'h1F), 1);
    ahb(1'h1, CPS_OFS_CTRL, 32'h1);
    ahb(1'h1, CPS_OFS_CTRL, 32'h0);
    for (int i = 0; i < 9000 && counters_clear !== 1'h1; i++) @(posedge hclk);
    counting = 1'h0;
    chk("bits", 32'(nticks >= 1419 && nticks <= 1420), 1);
    ahb(1'h0, CPS_OFS_STATUS, 32'h0);
    chk("bus on", r[7], 1'h0);
    chk("released", init_hold_bit, 1'h0);
  endtask : t_busoff
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    {hresetn, hsel, hwrite, passive_state, enter_bus_off} = 5'h00;
    {event_valid, data_phase, fd_crc_fixed_stuff, slow, counting} = 5'h00;
    {haddr, hwdata, htrans, tx_fault_count, rx_fault_count} = 84'h0;
    hsize = 3'h2;
    activity_state = 2'h1;
    event_kind = CPS_EV_NONE;
    {n_fail, comparisons, nticks} = 96'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_flags;
    t_codes;
    t_busoff;
    wrap_up;
  end
  // Whole run needs under 8000 clocks; cut off at 20000
  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule : cps_status_bench

//--- design/cps_pkg.sv
// Purpose: Shared constants for the CAN protocol status block.
// Assumes: AHB-Lite register access, 32-bit data, word registers.
// Notes: Offsets are byte addresses of aligned words.
package cps_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CPS_OFS_STATUS = 8'h00; // Protocol status
  localparam logic [7:0] CPS_OFS_CTRL = 8'h04; // Init hold control
  localparam logic [7:0] CPS_OFS_CNT = 8'h08; // Fault counters
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CPS_BIT_BUS_OFF = 7;
  localparam int CPS_BIT_WARN = 6;
  localparam int CPS_BIT_PASSIVE = 5;
  localparam int CPS_POS_ACT = 3;
  localparam int CPS_POS_LEC = 0;
  localparam int CPS_POS_DATA_PHASE_FAULT_CODE = 8;
  localparam int CPS_POS_REC = 8;
  // ****************************************************************
  // Fault codes and limits
  // ****************************************************************
  localparam logic [2:0] CPS_CODE_NONE = 3'h0;
  localparam logic [2:0] CPS_CODE_STUFF = 3'h1;
  localparam logic [2:0] CPS_CODE_FORM = 3'h2;
  localparam logic [2:0] CPS_CODE_ACK = 3'h3;
  localparam logic [2:0] CPS_CODE_BIT1 = 3'h4;
  localparam logic [2:0] CPS_CODE_BIT0 = 3'h5;
  localparam logic [2:0] CPS_CODE_CRC = 3'h6;
  localparam logic [2:0] CPS_CODE_NOCHG = 3'h7;
  localparam logic [8:0] CPS_WARN_LIMIT = 9'h060; // 96
  localparam logic [7:0] CPS_IDLE_RUNS = 8'h81; // 129
  localparam logic [3:0] CPS_IDLE_BITS = 4'hB; // 11
  // Event kinds presented by the protocol engine
  typedef enum logic [2:0] {
    CPS_EV_OK, CPS_EV_STUFF, CPS_EV_FORM, CPS_EV_ACK,
    CPS_EV_BIT1, CPS_EV_BIT0, CPS_EV_CRC, CPS_EV_NONE
  } cps_event_t;
endpackage : cps_pkg

//--- design/cps_recovery.sv
// Purpose: Bus-off recovery sequencer counting idle runs.
// Assumes: One recessive sample pulse per bit time from bit timing.
// Notes: Init hold changes during waiting never shorten the wait.
`timescale 1ns/100ps
module cps_recovery (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bus_off_flag,
  input wire logic init_hold_bit,
  input wire logic bit_tick,
  input wire logic bit_recessive,
  output logic waiting,
  output logic run_seen,
  output logic [7:0] run_count,
  output logic done
);
  import cps_pkg::*;
  // ****************************************************************
  // Recovery state
  // ****************************************************************
  typedef enum logic [1:0] {CPS_R_IDLE, CPS_R_HOLD, CPS_R_WAIT}
    cps_rstate_t;
  cps_rstate_t state_reg, state_next; // Sequencer state
  logic [3:0] bits_reg, bits_next; // Recessive bits in current run
  logic [7:0] runs_reg, runs_next; // Completed idle runs
  logic seen_next, done_next;
  logic seen_reg, done_reg;

  // Next state; once waiting starts only the run count ends it
  always_comb begin
    state_next = state_reg;
    bits_next = bits_reg;
    runs_next = runs_reg;
    seen_next = 1'b0;
    done_next = 1'b0;
    unique case (state_reg)
      CPS_R_IDLE: begin
        // Bus-off still reads set the cycle after done; do not rearm
        if (bus_off_flag && !done_reg) begin
          state_next = CPS_R_HOLD;
        end
      end
      CPS_R_HOLD: begin
        // Stay off bus until host clears init hold
        if (!init_hold_bit) begin // RQ14
          state_next = CPS_R_WAIT;
          bits_next = 4'h0;
          runs_next = 8'h00;
        end
      end
      CPS_R_WAIT: begin
        // Init hold ignored here so the wait is never cut short
        if (bit_tick) begin // RQ13
          if (!bit_recessive) begin
            bits_next = 4'h0;
          end else if (bits_reg == CPS_IDLE_BITS - 4'h1) begin
            bits_next = 4'h0;
            runs_next = runs_reg + 8'h01;
            seen_next = 1'b1; // RQ17
            if (runs_reg == CPS_IDLE_RUNS - 8'h01) begin // RQ15
              state_next = CPS_R_IDLE;
              done_next = 1'b1;
            end
          end else begin
            bits_next = bits_reg + 4'h1;
          end
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= CPS_R_IDLE;
      bits_reg <= 4'h0;
      runs_reg <= 8'h00;
      seen_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bits_reg <= bits_next;
      runs_reg <= runs_next;
      seen_reg <= seen_next;
      done_reg <= done_next;
    end
  end

  assign waiting = (state_reg == CPS_R_WAIT);
  assign run_seen = seen_reg;
  assign run_count = runs_reg;
  assign done = done_reg;
endmodule : cps_recovery

//--- design/cps_status.sv
// Purpose: CAN protocol status, fault codes and bus-off handling.
// Assumes: Protocol engine supplies counters, state and event pulses.
// Notes: Registers reached over AHB-Lite, zero wait states.
//
// Behaviour
// [RQ1] Warning flag when a counter reaches 96
// [RQ2] Passive flag follows error passive state
// [RQ3] Activity field reports sync idle rx tx
// [RQ4] Fault code zero on clean frame
// [RQ5] Stuff violation records code one
// [RQ6] Form code two, missing ack three
// [RQ7] Bit1 fault four, bit0 fault five
// [RQ8] CRC mismatch records code six
// [RQ9] Status read restores code seven
// [RQ10] Data phase events go to data code
// [RQ11] FD CRC fixed stuff fault is form
// [RQ12] Bus-off sets init hold by itself
// [RQ13] Init changes never shorten recovery
// [RQ14] Host clears init hold to recover
// [RQ15] Wait 129 idle runs of 11 bits
// [RQ16] Recovery end clears both counters
// [RQ17] Each idle run writes code five
// [RQ18] Receive counter counts idle runs
// [RQ19] Data code same coding, reset seven
// [RQ20] Bus-off flag at bit seven
// [RQ21] Event wins over read restore
`timescale 1ns/100ps
module cps_status (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Protocol engine
  input wire logic [8:0] tx_fault_count,
  input wire logic [8:0] rx_fault_count,
  input wire logic passive_state,
  input wire logic enter_bus_off,
  input wire logic [1:0] activity_state,
  input wire logic event_valid,
  input wire cps_pkg::cps_event_t event_kind,
  input wire logic data_phase,
  input wire logic fd_crc_fixed_stuff,
  input wire logic bit_tick,
  input wire logic bit_recessive,
  // To engine
  output logic init_hold_bit,
  output logic counters_clear,
  output logic bus_off_flag
);
  import cps_pkg::*;
  // ****************************************************************
  // Bus interface
  // ****************************************************************
  logic ph_wr_reg, ph_wr_next; // Pending write data phase
  logic ph_rd_reg, ph_rd_next; // Read data phase, address taken last cycle
  logic [7:0] ph_ofs_reg, ph_ofs_next; // Latched offset
  logic [31:0] rdata_reg, rdata_next; // Read data flop
  logic addr_ok;

  // Valid address phase
  assign addr_ok = hsel & hready & htrans[1];

  // Convert an event to its code, with FD CRC stuff reclassified
  function automatic logic [2:0] cps_code(input cps_event_t k,
                                          input logic fix);
    logic [2:0] c;
    c = 3'(k);
    if (k == CPS_EV_STUFF && fix) begin
      c = CPS_CODE_FORM; // RQ11
    end
    return c;
  endfunction : cps_code

  // ****************************************************************
  // Status state
  // ****************************************************************
  logic [2:0] lec_reg, lec_next; // last_fault_code
  logic [2:0] data_phase_fault_code_reg, data_phase_fault_code_next; // data_phase_fault_code
  logic bo_reg, bo_next; // Bus-off state
  logic init_reg, init_next; // init_hold_bit
  logic [7:0] rec_runs; // Recovery run count
  logic rec_wait, rec_seen, rec_done;
  logic [31:0] status_word, cnt_word;
  logic status_read;

  // Recovery sequencer
  cps_recovery u_recovery (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus_off_flag(bo_reg),
    .init_hold_bit(init_reg),
    .bit_tick(bit_tick),
    .bit_recessive(bit_recessive),
    .waiting(rec_wait),
    .run_seen(rec_seen),
    .run_count(rec_runs),
    .done(rec_done)
  );

  // Status read happens when the address phase is a read of status
  assign status_read = addr_ok & !hwrite &
    (haddr[7:0] == CPS_OFS_STATUS);

  // Assemble the status word; reserved bits zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CPS_BIT_BUS_OFF] = bo_reg; // RQ20
    status_word[CPS_BIT_WARN] = (tx_fault_count >= CPS_WARN_LIMIT) |
      (rx_fault_count >= CPS_WARN_LIMIT); // RQ1
    status_word[CPS_BIT_PASSIVE] = passive_state; // RQ2
    status_word[CPS_POS_ACT +: 2] = activity_state; // RQ3
    status_word[CPS_POS_LEC +: 3] = lec_reg;
    status_word[CPS_POS_DATA_PHASE_FAULT_CODE +: 3] = data_phase_fault_code_reg; // RQ19
  end

  // Counter view; during recovery receive count shows idle runs
  always_comb begin
    cnt_word = 32'h0000_0000;
    cnt_word[7:0] = tx_fault_count[7:0];
    if (rec_wait) begin
      cnt_word[CPS_POS_REC +: 8] = rec_runs; // RQ18
    end else begin
      cnt_word[CPS_POS_REC +: 9] = rx_fault_count;
    end
  end

  // Fault code, bus-off and init hold next values
  always_comb begin
    lec_next = lec_reg;
    data_phase_fault_code_next = data_phase_fault_code_reg;
    bo_next = bo_reg;
    init_next = init_reg;
    // Read restore first so any event below overrides it
    if (status_read) begin
      lec_next = CPS_CODE_NOCHG; // RQ9
    end
    if (event_valid && event_kind != CPS_EV_NONE) begin // RQ21
      if (data_phase) begin
        // Data phase events of switched frames
        data_phase_fault_code_next = cps_code(event_kind, fd_crc_fixed_stuff); // RQ10
      end else begin
        // OK maps to zero, others to codes one to six
        lec_next = cps_code(event_kind, fd_crc_fixed_stuff); // RQ4
      end // RQ5 RQ6 RQ7 RQ8
    end
    if (rec_seen) begin
      lec_next = CPS_CODE_BIT0; // RQ17
    end
    // Host write of init hold, applied before hardware set
    if (ph_wr_reg && ph_ofs_reg == CPS_OFS_CTRL) begin
      init_next = hwdata[0];
    end
    if (enter_bus_off) begin
      bo_next = 1'b1;
      init_next = 1'b1; // RQ12
    end
    if (rec_done) begin
      bo_next = 1'b0;
    end
  end

  // Engine counter reset at recovery end
  assign counters_clear = rec_done; // RQ16

  // Bus phase next values
  always_comb begin
    ph_wr_next = addr_ok & hwrite;
    ph_rd_next = addr_ok & !hwrite;
    ph_ofs_next = addr_ok ? haddr[7:0] : ph_ofs_reg;
    rdata_next = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        CPS_OFS_STATUS: rdata_next = status_word;
        CPS_OFS_CTRL: rdata_next = {31'h0000_0000, init_reg};
        CPS_OFS_CNT: rdata_next = cnt_word;
        default: rdata_next = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lec_reg <= CPS_CODE_NOCHG;
      data_phase_fault_code_reg <= CPS_CODE_NOCHG;
      bo_reg <= 1'b0;
      init_reg <= 1'b1;
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_ofs_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      lec_reg <= lec_next;
      data_phase_fault_code_reg <= data_phase_fault_code_next;
      bo_reg <= bo_next;
      init_reg <= init_next;
      ph_wr_reg <= ph_wr_next;
      ph_rd_reg <= ph_rd_next;
      ph_ofs_reg <= ph_ofs_next;
      rdata_reg <= rdata_next;
    end
  end

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign init_hold_bit = init_reg;
  assign bus_off_flag = bo_reg;
endmodule : cps_status
